// ### logic/sfscc_pkg.sv
package sfscc_pkg;

	//------------------------------------------------------------
	// clock and timing figures
	//------------------------------------------------------------
	localparam int  CLK_MHZ     = 100;
	localparam int  PP_LIM_MS   = 10;
	localparam int  SE_LIM_S    = 2;
	localparam int  CE_LIM_S    = 10;
	localparam int  PP_BYTE_US  = 30;
	localparam real PP_LONG_MS  = 1.5;
	localparam int  SE_TYP_MS   = 25;
	localparam int  CE_TYP_MS   = 250;
	localparam int  SRW_TYP_MS  = 5;
	localparam int  PP_BYTE_CYC = PP_BYTE_US * CLK_MHZ;

	//------------------------------------------------------------
	// sizes
	//------------------------------------------------------------
	localparam int PAGE_BYTES   = 256;
	localparam int SHORT_PP_MAX = 32;
	localparam int FIFO_DEPTH   = 8;

	//------------------------------------------------------------
	// opcodes
	//------------------------------------------------------------
	localparam logic [7:0] OP_STAT_RD  = 8'h05;
	localparam logic [7:0] OP_STAT_WR  = 8'h01;
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_WR_DIS   = 8'h04;
	localparam logic [7:0] OP_PDOWN    = 8'hB9;
	localparam logic [7:0] OP_SEC_ERS  = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERS = 8'hC7;
	localparam logic [7:0] OP_PAGE_PGM = 8'h02;
	localparam logic [7:0] OP_ID_RD    = 8'hAB;
	localparam logic [7:0] OP_SW_RST   = 8'hFF;

	//------------------------------------------------------------
	// carriers
	//------------------------------------------------------------
	typedef struct packed {
		logic status_write_lock;
		logic reserved6;
		logic timeout_err;
		logic block_protect_bit2;
		logic block_protect_bit1;
		logic block_protect_bit0;
		logic write_enable;
		logic busy_indicator_alias;
	} sfscc_status_t;

	localparam sfscc_status_t STAT_RST = 8'h00;

	typedef struct packed {
		logic [18:0] addr;
		logic [7:0]  data;
	} sfscc_pgm_t;

	typedef struct packed {
		logic       req;
		logic       whole;
		logic [2:0] sector;
	} sfscc_ers_t;

	typedef enum logic [2:0] {ST_IDLE, ST_SWR, ST_ERASE, ST_PROG, ST_STUCK} sfscc_st_t;

endpackage

// ### logic/sfscc_top.sv
`timescale 1ns/100ps

module sfscc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         mclk,      // system clock
	input  wire logic         nrst,      // async reset, active low
	input  wire logic         flush,     // drop all entries
	input  wire logic         in_valid,  // write request
	output logic              in_ready,  // room available
	input  wire logic [W-1:0] in_data,   // write word
	output logic              out_valid, // word available
	input  wire logic         out_ready, // reader takes word
	output logic [W-1:0]      out_data   // head word
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [D];
	logic [AW:0]  wr_ff;
	logic [AW:0]  rd_ff;
	logic         push;
	logic         pop;

	assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(D);
	assign out_valid = wr_ff != rd_ff;
	assign out_data  = mem_ff[rd_ff[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else if (flush)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else
		begin
			wr_ff <= wr_ff + (AW+1)'(push);
			rd_ff <= rd_ff + (AW+1)'(pop);
		end
	end
endmodule // sfscc_fifo

module sfscc_top #(
	parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] PART_ID  = 8'h3C, // arbitrary value
	parameter int PP_LONG_CYC = int'(sfscc_pkg::PP_LONG_MS * 1000.0 * sfscc_pkg::CLK_MHZ),
	parameter int PP_LIM_CYC  = sfscc_pkg::PP_LIM_MS * 1000 * sfscc_pkg::CLK_MHZ,
	parameter int SE_LIM_CYC  = sfscc_pkg::SE_LIM_S * 1000000 * sfscc_pkg::CLK_MHZ,
	parameter int CE_LIM_CYC  = sfscc_pkg::CE_LIM_S * 1000000 * sfscc_pkg::CLK_MHZ,
	parameter int SE_DUR_CYC  = sfscc_pkg::SE_TYP_MS * 1000 * sfscc_pkg::CLK_MHZ,
	parameter int CE_DUR_CYC  = sfscc_pkg::CE_TYP_MS * 1000 * sfscc_pkg::CLK_MHZ,
	parameter int SRW_DUR_CYC = sfscc_pkg::SRW_TYP_MS * 1000 * sfscc_pkg::CLK_MHZ
) (
	input  wire logic                 mclk,      // system clock
	input  wire logic                 nrst,      // async reset, active low
	input  wire logic                 sck,       // serial clock pin
	input  wire logic                 cs_n,      // chip select pin
	input  wire logic                 si,        // serial data in pin
	input  wire logic                 wp_n,      // write-protect pin
	output logic                      so,        // serial data out
	output logic                      so_oe_n,   // low while driving so
	input  wire logic                 arr_ready, // array accepts word / erase done
	output sfscc_pkg::sfscc_pgm_t     pgm,       // program word to array
	output logic                      pgm_valid, // program word valid
	output sfscc_pkg::sfscc_ers_t     ers,       // erase request to array
	output sfscc_pkg::sfscc_status_t  status,    // status register
	output logic                      pdown      // power-down state
);

	//------------------------------------------------------------
	// pin synchronisers and edges
	//------------------------------------------------------------
	logic [2:0] sck_s_ff;
	logic [2:0] cs_s_ff;
	logic [1:0] si_s_ff;
	logic [1:0] wp_s_ff;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_s_ff <= 3'h0;
			cs_s_ff  <= 3'h7;
			si_s_ff  <= 2'h0;
			wp_s_ff  <= 2'h3;
		end
		else
		begin
			sck_s_ff <= {sck_s_ff[1:0], sck};
			cs_s_ff  <= {cs_s_ff[1:0], cs_n};
			si_s_ff  <= {si_s_ff[0], si};
			wp_s_ff  <= {wp_s_ff[0], wp_n};
		end
	end

	logic sel;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;

	assign sel      = ~cs_s_ff[1];
	assign sck_rise = sck_s_ff[1] & ~sck_s_ff[2];
	assign sck_fall = ~sck_s_ff[1] & sck_s_ff[2];
	assign cs_rise  = cs_s_ff[1] & ~cs_s_ff[2];

	//------------------------------------------------------------
	// frame receiver
	//------------------------------------------------------------
	logic [2:0]  bit_ff;
	logic [2:0]  bcnt_ff;
	logic [7:0]  sh_ff;
	logic [7:0]  op_ff;
	logic [23:0] addr_ff;
	logic [7:0]  swdata_ff;
	logic [7:0]  rx;
	logic        byte_end;

	assign rx       = {sh_ff[6:0], si_s_ff[1]};
	assign byte_end = sel & sck_rise & (bit_ff == 3'h7);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_ff    <= 3'h0;
			bcnt_ff   <= 3'h0;
			sh_ff     <= 8'h00;
			op_ff     <= 8'h00;
			addr_ff   <= 24'h000000;
			swdata_ff <= 8'h00;
		end
		else if (!sel)
		begin
			bit_ff  <= 3'h0;
			bcnt_ff <= 3'h0;
		end
		else if (sck_rise)
		begin
			sh_ff  <= rx;
			bit_ff <= bit_ff + 3'h1;
			if (byte_end)
			begin
				if (bcnt_ff != 3'h5)
				begin
					bcnt_ff <= bcnt_ff + 3'h1;
				end
				if (bcnt_ff == 3'h0)
				begin
					op_ff <= rx;
				end
				else if (bcnt_ff < 3'h4)
				begin
					addr_ff <= {addr_ff[15:0], rx};
				end
				if (bcnt_ff == 3'h1)
				begin
					swdata_ff <= rx;
				end
			end
		end
	end

	//------------------------------------------------------------
	// page buffer
	//------------------------------------------------------------
	sfscc_pkg::sfscc_st_t st_ff;
	logic [7:0] page_mem [sfscc_pkg::PAGE_BYTES];
	logic [7:0] ld_ff;
	logic [8:0] n_ff;
	logic       ld_en;

	assign ld_en = byte_end & (bcnt_ff >= 3'h4) & (op_ff == sfscc_pkg::OP_PAGE_PGM)
		& (st_ff == sfscc_pkg::ST_IDLE);

	always_ff @(posedge mclk)
	begin
		if (ld_en)
		begin
			page_mem[ld_ff] <= rx;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ld_ff <= 8'h00;
			n_ff  <= 9'h000;
		end
		else if (byte_end & (bcnt_ff == 3'h0))
		begin
			ld_ff <= 8'h00;
			n_ff  <= 9'h000;
		end
		else if (ld_en)
		begin
			ld_ff <= ld_ff + 8'h01;
			if (n_ff != 9'(sfscc_pkg::PAGE_BYTES))
			begin
				n_ff <= n_ff + 9'h001;
			end
		end
	end

	//------------------------------------------------------------
	// command decode at chip select rise
	//------------------------------------------------------------
	sfscc_pkg::sfscc_status_t stat_ff;
	logic       pdn_ff;
	logic       busy;
	logic       go;
	logic       idle_ok;
	logic [2:0] bp;
	logic       wen_set;
	logic       wen_clr;
	logic       pdn_set;
	logic       pdn_clr;
	logic       rst_go;
	logic       se_go;
	logic       ce_go;
	logic       pp_go;
	logic       sw_go;

	function automatic logic sec_prot(input logic [2:0] b, input logic [2:0] sec);
		sec_prot = b[2] | ((b[1:0] == 2'h1) & (sec == 3'h7))
			| ((b[1:0] == 2'h2) & (sec[2:1] == 2'h3)) | ((b[1:0] == 2'h3) & sec[2]);
	endfunction

	assign busy    = st_ff != sfscc_pkg::ST_IDLE;
	assign bp      = {stat_ff.block_protect_bit2, stat_ff.block_protect_bit1,
		stat_ff.block_protect_bit0};
	assign go      = cs_rise & (bit_ff == 3'h0);
	assign idle_ok = go & ~busy & ~pdn_ff;
	assign wen_set = idle_ok & (op_ff == sfscc_pkg::OP_WR_EN) & (bcnt_ff == 3'h1);
	assign wen_clr = idle_ok & (op_ff == sfscc_pkg::OP_WR_DIS) & (bcnt_ff == 3'h1);
	assign pdn_set = idle_ok & (op_ff == sfscc_pkg::OP_PDOWN) & (bcnt_ff == 3'h1);
	assign pdn_clr = go & ~busy & (op_ff == sfscc_pkg::OP_ID_RD);
	assign rst_go  = go & (op_ff == sfscc_pkg::OP_SW_RST) & (bcnt_ff == 3'h1)
		& ((st_ff == sfscc_pkg::ST_STUCK) | (~busy & ~pdn_ff));
	assign se_go   = idle_ok & stat_ff.write_enable & (op_ff == sfscc_pkg::OP_SEC_ERS)
		& (bcnt_ff >= 3'h4) & ~sec_prot(bp, addr_ff[18:16]);
	assign ce_go   = idle_ok & stat_ff.write_enable & (op_ff == sfscc_pkg::OP_CHIP_ERS)
		& (bcnt_ff == 3'h1) & (bp == 3'h0);
	assign pp_go   = idle_ok & stat_ff.write_enable & (op_ff == sfscc_pkg::OP_PAGE_PGM)
		& (bcnt_ff == 3'h5) & ~sec_prot(bp, addr_ff[18:16]);
	assign sw_go   = idle_ok & stat_ff.write_enable & (op_ff == sfscc_pkg::OP_STAT_WR)
		& (bcnt_ff >= 3'h2) & (wp_s_ff[1] | ~stat_ff.status_write_lock);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pdn_ff <= 1'b0;
		end
		else if (pdn_set)
		begin
			pdn_ff <= 1'b1;
		end
		else if (pdn_clr)
		begin
			pdn_ff <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// operation sequencer
	//------------------------------------------------------------
	logic [31:0] cnt_ff;
	logic [31:0] dur_ff;
	logic [31:0] lim_ff;
	logic [7:0]  rd_ff;
	logic [8:0]  left_ff;
	logic [7:0]  pi_ff;
	logic        fin;
	logic        op_done;
	logic        op_tmo;
	logic        f_in_ready;
	logic        f_out_valid;
	logic        push;
	sfscc_pkg::sfscc_pgm_t f_in;
	sfscc_pkg::sfscc_pgm_t f_out;

	always_comb
	begin
		unique case (st_ff)
			sfscc_pkg::ST_ERASE: fin = arr_ready;
			sfscc_pkg::ST_PROG:  fin = (left_ff == 9'h000) & ~f_out_valid & ~pgm_valid;
			sfscc_pkg::ST_SWR:   fin = 1'b1;
			default:             fin = 1'b0;
		endcase
	end

	assign op_done = busy & (st_ff != sfscc_pkg::ST_STUCK) & (cnt_ff >= dur_ff) & fin;
	assign op_tmo  = busy & (st_ff != sfscc_pkg::ST_STUCK) & ~op_done
		& (lim_ff != 32'h0) & (cnt_ff >= lim_ff);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff  <= sfscc_pkg::ST_IDLE;
			cnt_ff <= 32'h0;
			dur_ff <= 32'h0;
			lim_ff <= 32'h0;
		end
		else
		begin
			cnt_ff <= cnt_ff + 32'h1;
			unique case (st_ff)
				sfscc_pkg::ST_IDLE:
				begin
					cnt_ff <= 32'h0;
					if (sw_go)
					begin
						st_ff  <= sfscc_pkg::ST_SWR;
						dur_ff <= 32'(SRW_DUR_CYC);
						lim_ff <= 32'h0;
					end
					else if (se_go | ce_go)
					begin
						st_ff  <= sfscc_pkg::ST_ERASE;
						dur_ff <= se_go ? 32'(SE_DUR_CYC) : 32'(CE_DUR_CYC);
						lim_ff <= se_go ? 32'(SE_LIM_CYC) : 32'(CE_LIM_CYC);
					end
					else if (pp_go)
					begin
						st_ff  <= sfscc_pkg::ST_PROG;
						dur_ff <= (n_ff <= 9'(sfscc_pkg::SHORT_PP_MAX))
							? 32'(32'(n_ff) * 32'(sfscc_pkg::PP_BYTE_CYC)) : 32'(PP_LONG_CYC);
						lim_ff <= 32'(PP_LIM_CYC);
					end
				end
				sfscc_pkg::ST_STUCK:
				begin
					cnt_ff <= 32'h0;
					if (rst_go)
					begin
						st_ff <= sfscc_pkg::ST_IDLE;
					end
				end
				default:
				begin
					if (op_done)
					begin
						st_ff <= sfscc_pkg::ST_IDLE;
					end
					else if (op_tmo)
					begin
						st_ff <= sfscc_pkg::ST_STUCK;
					end
				end
			endcase
		end
	end

	// erase request held until the array finishes or reset aborts
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ers <= '0;
		end
		else if (se_go | ce_go)
		begin
			ers.req    <= 1'b1;
			ers.whole  <= ce_go;
			ers.sector <= addr_ff[18:16];
		end
		else if (op_done | rst_go)
		begin
			ers.req <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// program feed through the fifo
	//------------------------------------------------------------
	assign push = (st_ff == sfscc_pkg::ST_PROG) & (left_ff != 9'h000) & f_in_ready;
	assign f_in = '{addr: {addr_ff[18:8], 8'(addr_ff[7:0] + pi_ff)}, data: page_mem[rd_ff]};

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_ff   <= 8'h00;
			left_ff <= 9'h000;
			pi_ff   <= 8'h00;
		end
		else if (pp_go)
		begin
			rd_ff   <= (n_ff == 9'(sfscc_pkg::PAGE_BYTES)) ? ld_ff : 8'h00;
			left_ff <= n_ff;
			pi_ff   <= 8'h00;
		end
		else if (rst_go)
		begin
			left_ff <= 9'h000;
		end
		else if (push)
		begin
			rd_ff   <= rd_ff + 8'h01;
			left_ff <= left_ff - 9'h001;
			pi_ff   <= pi_ff + 8'h01;
		end
	end

	sfscc_fifo #(
		.W ($bits(sfscc_pkg::sfscc_pgm_t)),
		.D (sfscc_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.flush     (rst_go),
		.in_valid  (push),
		.in_ready  (f_in_ready),
		.in_data   (f_in),
		.out_valid (f_out_valid),
		.out_ready (~pgm_valid | arr_ready),
		.out_data  (f_out)
	);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pgm       <= '0;
			pgm_valid <= 1'b0;
		end
		else if (rst_go)
		begin
			pgm_valid <= 1'b0;
		end
		else if (f_out_valid & (~pgm_valid | arr_ready))
		begin
			pgm       <= f_out;
			pgm_valid <= 1'b1;
		end
		else if (arr_ready)
		begin
			pgm_valid <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// status register
	//------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			stat_ff <= sfscc_pkg::STAT_RST;
		end
		else
		begin
			stat_ff.busy_indicator_alias <= busy;
			stat_ff.reserved6            <= 1'b0;
			if (wen_set)
			begin
				stat_ff.write_enable <= 1'b1;
			end
			else if (wen_clr | op_done)
			begin
				stat_ff.write_enable <= 1'b0;
			end
			if (op_tmo)
			begin
				stat_ff.timeout_err <= 1'b1;
			end
			else if (rst_go)
			begin
				stat_ff.timeout_err <= 1'b0;
			end
			if (op_done & (st_ff == sfscc_pkg::ST_SWR))
			begin
				stat_ff.status_write_lock  <= swdata_ff[7];
				stat_ff.block_protect_bit2 <= swdata_ff[4];
				stat_ff.block_protect_bit1 <= swdata_ff[3];
				stat_ff.block_protect_bit0 <= swdata_ff[2];
			end
		end
	end

	assign status = stat_ff;
	assign pdown  = pdn_ff;

	//------------------------------------------------------------
	// serial output
	//------------------------------------------------------------
	logic [2:0] oidx_ff;
	logic       id_tog_ff;
	logic       out_act;
	logic [7:0] src;

	assign out_act = sel & ((op_ff == sfscc_pkg::OP_STAT_RD) & (bcnt_ff != 3'h0) & ~pdn_ff
		| (op_ff == sfscc_pkg::OP_ID_RD) & (bcnt_ff >= 3'h4) & ~busy);
	assign src = (op_ff == sfscc_pkg::OP_STAT_RD) ? stat_ff
		: ((id_tog_ff ^ addr_ff[0]) ? PART_ID : MAKER_ID);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			so        <= 1'b0;
			so_oe_n   <= 1'b1;
			oidx_ff   <= 3'h0;
			id_tog_ff <= 1'b0;
		end
		else if (!sel)
		begin
			so_oe_n   <= 1'b1;
			oidx_ff   <= 3'h0;
			id_tog_ff <= 1'b0;
		end
		else if (sck_fall & out_act)
		begin
			so      <= src[3'(3'h7 - oidx_ff)];
			so_oe_n <= 1'b0;
			oidx_ff <= oidx_ff + 3'h1;
			if (oidx_ff == 3'h7)
			begin
				id_tog_ff <= ~id_tog_ff;
			end
		end
	end

endmodule // sfscc_top

// ### testbench/sfscc_top_asserts.sv
`timescale 1ns/100ps

module sfscc_chk (
	input wire logic                     mclk,      // system clock
	input wire logic                     nrst,      // reset, active low
	input wire logic                     sck,       // serial clock
	input wire logic                     cs_n,      // chip select
	input wire logic                     si,        // serial in
	input wire logic                     wp_n,      // write protect
	input wire logic                     so,        // serial out
	input wire logic                     so_oe_n,   // out enable, low
	input wire logic                     arr_ready, // array ready
	input wire sfscc_pkg::sfscc_pgm_t    pgm,       // program word
	input wire logic                     pgm_valid, // word valid
	input wire sfscc_pkg::sfscc_ers_t    ers,       // erase request
	input wire sfscc_pkg::sfscc_status_t status,    // status register
	input wire logic                     pdown      // power down
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	logic [3:0] free_top;
	// first protected sector
	always_comb
	begin
		case ({status.block_protect_bit1, status.block_protect_bit0})
			2'b01: free_top = 4'h7;
			2'b10: free_top = 4'h6;
			2'b11: free_top = 4'h4;
			default: free_top = 4'h8;
		endcase
	end

	a_sector_prot: assert property (
		$rose(ers.req) && !ers.whole |-> {1'b0, ers.sector} < free_top && !status.block_protect_bit2)
		else $error("sector erase in protected area");
	a_chip_level0: assert property (
		ers.req && ers.whole |-> status[4:2] == 3'h0)
		else $error("chip erase with protection set");
	a_erase_wen: assert property ($rose(ers.req) |-> status.write_enable)
		else $error("erase without write enable");
	a_erase_busy: assert property (
		$rose(ers.req) |-> ##[0:3] status.busy_indicator_alias)
		else $error("busy missing during erase");
	a_stuck_busy: assert property (status.timeout_err |-> status.busy_indicator_alias)
		else $error("timeout without busy");
	a_wen_drop: assert property (
		$fell(status.busy_indicator_alias) && !$past(status.timeout_err, 2)
		&& !$past(status.timeout_err, 3) |-> !status.write_enable)
		else $error("write enable kept after write");
	a_idle_hiz: assert property (cs_n [*6] |-> so_oe_n)
		else $error("output driven while deselected");
	a_so_on_fall: assert property (
		!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !$past(sck, 2))
		else $error("output changed off falling edge");
	a_pgm_hold: assert property (
		pgm_valid && !arr_ready && !status.timeout_err |=> pgm_valid && $stable(pgm))
		else $error("program word dropped");
	a_pdown_idle: assert property (pdown |-> !ers.req && !status.busy_indicator_alias)
		else $error("write active in power down");
endmodule // sfscc_chk

bind sfscc_top sfscc_chk i_chk (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
	.wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .arr_ready(arr_ready), .pgm(pgm),
	.pgm_valid(pgm_valid), .ers(ers), .status(status), .pdown(pdown));

// ### testbench/sfscc_host.sv
`timescale 1ns/100ps

module sfscc_host (
	input  wire logic mclk,    // system clock
	output logic      sck,     // serial clock, idle low
	output logic      cs_n,    // chip select
	output logic      si,      // data to device
	input  wire logic so,      // data from device
	input  wire logic so_oe_n  // device drives so when low
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic open();
		tick(4);
		cs_n = 1'b0;
		tick(4);
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			si = tx[i];
			tick(4);
			sck = 1'b1;
			tick(4);
			rx[i] = so_oe_n ? 1'bx : so;
			sck = 1'b0;
		end
	endtask

	// released line shows a fresh value
	task automatic close();
		tick(4);
		cs_n = 1'b1;
		si = ~si;
		tick(4);
	endtask
endmodule // sfscc_host

// ### testbench/serial_flash_status_command_control_test.sv
`timescale 1ns/100ps

module serial_flash_status_command_control_test;
	localparam logic [7:0] MK_ID = 8'hA5; // arbitrary value, left at module default
	localparam logic [7:0] PT_ID = 8'h3C; // arbitrary value, left at module default
	logic                     mclk, nrst, sck, cs_n, si, wp_n, so, so_oe_n;
	logic                     arr_ready, pgm_valid, pdown;
	sfscc_pkg::sfscc_pgm_t    pgm, first_wr;
	sfscc_pkg::sfscc_ers_t    ers;
	sfscc_pkg::sfscc_status_t status;
	int                       error_cnt, cmp_count, n_wr;
	logic [63:0]              r;

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	sfscc_host i_host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

	sfscc_top #(.PP_LONG_CYC(100), .SE_LIM_CYC(400), .SE_DUR_CYC(50), .CE_DUR_CYC(80),
		.SRW_DUR_CYC(20)) i_dut (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
		.wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .arr_ready(arr_ready), .pgm(pgm),
		.pgm_valid(pgm_valid), .ers(ers), .status(status), .pdown(pdown));

	// array side: count taken words
	always @(posedge mclk)
	begin
		if (pgm_valid === 1'b1 && arr_ready === 1'b1)
		begin
			if (n_wr == 0)
				first_wr = pgm;
			n_wr++;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic frm(input logic [63:0] tx, input int n);
		logic [7:0] b;
		r = '0;
		i_host.open();
		for (int k = n - 1; k >= 0; k--)
		begin
			i_host.xfer(tx[8*k +: 8], b);
			r[8*k +: 8] = b;
		end
		i_host.close();
	endtask

	task automatic one(input logic [7:0] op);
		frm({56'h0, op}, 1);
	endtask

	task automatic st(input logic [7:0] e);
		frm({sfscc_pkg::OP_STAT_RD, 8'h00}, 2);
		chk("status", e, r[7:0]);
	endtask

	task automatic idle();
		i_host.tick(4);
		for (int i = 0; i < 9000 && status.busy_indicator_alias !== 1'b0; i++)
			i_host.tick(1);
	endtask

	task automatic t_regs();
		chk("reset", 10'h001, {status, pdown, so_oe_n});
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_STAT_RD, 16'h0}, 3);
		chk("first", 8'h02, r[15:8]);
		chk("wrap", 8'h02, r[7:0]);
		one(sfscc_pkg::OP_WR_DIS);
		st(8'h00);
	endtask

	task automatic t_swr();
		frm({sfscc_pkg::OP_STAT_WR, 8'hFF}, 2);
		idle();
		st(8'h00);
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_STAT_WR, 8'hFF}, 2);
		idle();
		st(8'h9C);
		wp_n = 1'b0;
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_STAT_WR, 8'h00}, 2);
		idle();
		st(8'h9E);
		wp_n = 1'b1;
		frm({sfscc_pkg::OP_STAT_WR, 8'h04}, 2);
		idle();
		st(8'h04);
		one(sfscc_pkg::OP_WR_EN);
		n_wr = 0;
		frm({sfscc_pkg::OP_SEC_ERS, 24'h070000}, 4);
		one(sfscc_pkg::OP_CHIP_ERS);
		frm({sfscc_pkg::OP_PAGE_PGM, 32'h07000011}, 5);
		idle();
		st(8'h06);
		chk("prot words", 0, n_wr);
		frm({sfscc_pkg::OP_STAT_WR, 8'h00}, 2);
		idle();
	endtask

	task automatic t_erase();
		arr_ready = 1'b0;
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_SEC_ERS, 24'h160000}, 4);
		i_host.tick(4);
		chk("sector", 5'b10110, ers);
		st(8'h03);
		arr_ready = 1'b1;
		idle();
		st(8'h00);
		one(sfscc_pkg::OP_WR_EN);
		one(sfscc_pkg::OP_CHIP_ERS);
		i_host.tick(4);
		chk("chip", 5'b11000, ers);
		idle();
		st(8'h00);
	endtask

	task automatic t_tmo();
		arr_ready = 1'b0;
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_SEC_ERS, 24'h0}, 4);
		i_host.tick(450);
		st(8'h23);
		one(sfscc_pkg::OP_WR_DIS);
		st(8'h23);
		arr_ready = 1'b1;
		// host ends the locked erase
		one(sfscc_pkg::OP_SW_RST);
		idle();
		chk("release", 2'b00, {status.timeout_err, status.busy_indicator_alias});
		one(sfscc_pkg::OP_WR_DIS);
	endtask

	task automatic t_pgm();
		logic [7:0] b;
		n_wr = 0;
		arr_ready = 1'b0;
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_PAGE_PGM, 40'h012340A55A}, 6);
		i_host.tick(20);
		arr_ready = 1'b1;
		i_host.tick(5000);
		chk("short busy", 1'b1, status.busy_indicator_alias);
		idle();
		chk("short done", 1'b0, status.busy_indicator_alias);
		chk("words", 2, n_wr);
		chk("first", 27'h12340A5, first_wr);
		n_wr = 0;
		one(sfscc_pkg::OP_WR_EN);
		i_host.open();
		i_host.xfer(sfscc_pkg::OP_PAGE_PGM, b);
		repeat (3) i_host.xfer(8'h00, b);
		for (int i = 0; i < 257; i++)
			i_host.xfer(i[7:0], b);
		i_host.close();
		idle();
		chk("long words", 256, n_wr);
		chk("long first", 8'h01, first_wr.data);
		st(8'h00);
	endtask

	task automatic t_pd();
		one(sfscc_pkg::OP_PDOWN);
		i_host.tick(4);
		chk("pdown", 1'b1, pdown);
		one(sfscc_pkg::OP_WR_EN);
		frm({sfscc_pkg::OP_ID_RD, 40'h0000010000}, 6);
		chk("id part", {PT_ID, MK_ID}, r[15:0]);
		chk("release", 1'b0, pdown);
		st(8'h00);
		frm({sfscc_pkg::OP_ID_RD, 40'h0}, 6);
		chk("id maker", {MK_ID, PT_ID}, r[15:0]);
	endtask

	task automatic results();
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (80000) @(posedge mclk);
		error_cnt++;
		results();
	end

	initial
	begin
		nrst = 1'b0;
		wp_n = 1'b1;
		arr_ready = 1'b1;
		error_cnt = 0;
		cmp_count = 0;
		n_wr = 0;
		i_host.tick(6);
		nrst = 1'b1;
		t_regs();
		t_swr();
		t_erase();
		t_tmo();
		t_pgm();
		t_pd();
		results();
	end
endmodule // serial_flash_status_command_control_test
